/* rtl/etnc_top.sv */
// Purpose: Seconds timestamp, event log and diagnostic interrupt control
// Assumes: commands arrive as one-cycle strobes on core_clk
// Notes:   Button input is a pin and is synchronised here
`timescale 1ns/100ps
// How it works
// - 32-bit timestamp advances once per second
// - Controller reset clears timestamp to zero
// - Set-time loads value, keeps advancing
// - Both get-time commands return counter
// - Low values mean time since initialisation; every value is flagged relative
// - NMI pulse lasts 200 ms from its latest fire
// - Chassis diagnostic command pulses, no log
// - Button press pulses and logs 13h/6Fh
// - Filter match with NMI action pulses
// - Pre-timeout with NMI action pulses
// - After one pulse, lock until system reset
// - Pre-timeout with SMI action asserts SMI
// - Event log holds at most 92 entries
// - External events logged then sent to filter; one meeting a button press is dropped
// - Log clear may take up to a minute
module etnc_top
    import etnc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              sys_reset,
    input  wire logic              set_time_stb,
    input  wire logic [TS_W-1:0]   set_time_val,
    input  wire logic              get_log_time_stb,
    input  wire logic              get_repo_time_stb,
    output logic                   time_valid,
    output logic      [TS_W-1:0]   time_value,
    output logic                   time_is_relative,
    input  wire logic              chassis_diag_stb,
    input  wire logic              diag_button_pin,
    input  wire logic              filter_nmi_match,
    input  wire logic              pretimeout_stb,
    input  wire logic              pretimeout_nmi_en,
    input  wire logic              pretimeout_smi_en,
    output logic                   nmi_out,
    output logic                   smi_out,
    input  wire logic              smi_ack,
    input  wire logic              evt_msg_stb,
    input  wire logic [7:0]        evt_msg_type,
    input  wire logic [7:0]        evt_msg_ofs,
    output logic                   evt_to_filter,
    output logic      [7:0]        filt_type,
    output logic      [7:0]        filt_ofs,
    input  wire logic              log_rd_stb,
    input  wire logic [LOG_AW-1:0] log_rd_addr,
    output logic      [LOG_DW-1:0] log_rd_data,
    output logic                   log_rd_valid,
    output logic      [LOG_AW-1:0] log_count,
    output logic                   log_full,
    input  wire logic              log_clear_stb,
    output logic                   log_clear_busy
);

    // Saturating-free increment used by the timestamp counter
    function automatic logic [31:0] inc32(input logic [31:0] v);
        return v + 32'h0000_0001;
    endfunction

    localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYCLES - 1);
    localparam logic [NMI_W-1:0] NMI_LAST  = NMI_W'(NMI_CYCLES - 1);
    localparam logic [LOG_AW-1:0] LOG_MAX  = LOG_AW'(LOG_DEPTH);

    // Timestamp and its prescaler
    logic [PRE_W-1:0] pre_reg;
    logic [TS_W-1:0]  ts_reg;
    wire              tick = (pre_reg == TICK_LAST);

    // Prescaler restarts on set-time so a full second follows
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= '0;
        end else if (tick || set_time_stb) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + PRE_W'(1);
        end
    end

    // Counter: load beats tick, wraps at 2^32
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ts_reg <= TS_RESET;
        end else if (set_time_stb) begin
            ts_reg <= set_time_val;
        end else if (tick) begin
            ts_reg <= inc32(ts_reg);
        end
    end

    // Both get-time commands answer next cycle
    wire get_any = get_log_time_stb | get_repo_time_stb;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            time_valid       <= 1'b0;
            time_value       <= '0;
            time_is_relative <= 1'b0;
        end else begin
            time_valid <= get_any;
            if (get_any) begin
                time_value <= ts_reg;
                // 32-bit value always under the 33-bit bound
                time_is_relative <= ({1'b0, ts_reg} <= TS_REL_LIMIT);
            end
        end
    end

    // Button pin: three flops, press on agreed rise
    logic [2:0] btn_sync_reg;
    logic       btn_state_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            btn_sync_reg  <= 3'h0;
            btn_state_reg <= 1'b0;
        end else begin
            btn_sync_reg <= {btn_sync_reg[1:0], diag_button_pin};
            if (btn_sync_reg[1] == btn_sync_reg[2]) begin
                btn_state_reg <= btn_sync_reg[2];
            end
        end
    end
    wire btn_press = (btn_sync_reg[1] == btn_sync_reg[2]) &
                     btn_sync_reg[2] & ~btn_state_reg;

    // Trigger merge: one pulse whatever the count
    wire pt_nmi  = pretimeout_stb & pretimeout_nmi_en;
    wire trig    = chassis_diag_stb | btn_press |
                   filter_nmi_match | pt_nmi;

    // Pulse width counter and lockout
    logic [NMI_W-1:0] nmi_cnt_reg;
    logic             lock_reg;
    wire              fire = trig & ~lock_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_out     <= 1'b0;
            nmi_cnt_reg <= '0;
            lock_reg    <= 1'b0;
        end else begin
            if (fire) begin
                nmi_out     <= 1'b1;
                nmi_cnt_reg <= '0;
                lock_reg    <= 1'b1;
            end else if (nmi_out) begin
                if (nmi_cnt_reg == NMI_LAST) begin
                    nmi_out <= 1'b0;
                end
                nmi_cnt_reg <= nmi_cnt_reg + NMI_W'(1);
            end
            // System reset releases lock; a live pulse ends naturally
            if (sys_reset && !fire) begin
                lock_reg <= 1'b0;
            end
        end
    end

    // SMI level held until the host acknowledges; set wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            smi_out <= 1'b0;
        end else if (pretimeout_stb && pretimeout_smi_en) begin
            smi_out <= 1'b1;
        end else if (smi_ack) begin
            smi_out <= 1'b0;
        end
    end

    // Log write: button event has priority over a message
    wire             log_req  = btn_press | evt_msg_stb;
    wire [7:0]       w_type   = btn_press ? SENS_CRIT_INT : evt_msg_type;
    wire [7:0]       w_ofs    = btn_press ? OFS_DIAG_BTN : evt_msg_ofs;
    wire             log_wr   = log_req & ~log_full & ~log_clear_busy;
    wire [LOG_DW-1:0] w_data  = {ts_reg, w_type, w_ofs};

    // Fill count; full at capacity, excess events dropped
    assign log_full = (log_count == LOG_MAX);
    etnc_clr_t clr_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            log_count <= '0;
            clr_reg   <= ETNC_CLR_IDLE;
        end else begin
            case (clr_reg)
                ETNC_CLR_IDLE: begin
                    if (log_clear_stb) begin
                        clr_reg <= ETNC_CLR_RUN;
                    end else if (log_wr) begin
                        log_count <= log_count + LOG_AW'(1);
                    end
                end
                ETNC_CLR_RUN: begin
                    // Clear takes one cycle here, well inside a minute
                    log_count <= '0;
                    clr_reg   <= ETNC_CLR_IDLE;
                end
                default: clr_reg <= ETNC_CLR_IDLE;
            endcase
        end
    end
    assign log_clear_busy = (clr_reg == ETNC_CLR_RUN);

    // Logged message handed to filtering one cycle later
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_to_filter <= 1'b0;
            filt_type     <= 8'h00;
            filt_ofs      <= 8'h00;
            log_rd_valid  <= 1'b0;
        end else begin
            evt_to_filter <= evt_msg_stb & ~btn_press;
            if (evt_msg_stb) begin
                filt_type <= evt_msg_type;
                filt_ofs  <= evt_msg_ofs;
            end
            log_rd_valid <= log_rd_stb;
        end
    end

    etnc_log_mem u_etnc_log_mem (
        .core_clk (core_clk),
        .wr_en    (log_wr),
        .wr_addr  (log_count),
        .wr_data  (w_data),
        .rd_addr  (log_rd_addr),
        .rd_data  (log_rd_data)
    );

    // Pulse stands until its width counter runs out
    property p_nmi_width;
        @(posedge core_clk) disable iff (!rst_n)
        (nmi_out && nmi_cnt_reg != NMI_LAST) |=> nmi_out;
    endproperty
    a_nmi_width: assert property (p_nmi_width)
        else $error("nmi pulse too short");

    // Lock holds and no trigger restarts the width count
    property p_lock;
        @(posedge core_clk) disable iff (!rst_n)
        (lock_reg && !sys_reset) |=> (lock_reg && nmi_cnt_reg != '0);
    endproperty
    a_lock: assert property (p_lock)
        else $error("nmi fired while locked");

    // Any trigger when unlocked starts a pulse
    property p_trig;
        @(posedge core_clk) disable iff (!rst_n)
        (trig && !lock_reg) |=> (nmi_out && lock_reg);
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger gave no pulse");

    // Set-time loads exactly
    property p_set;
        @(posedge core_clk) disable iff (!rst_n)
        set_time_stb |=> (ts_reg == $past(set_time_val));
    endproperty
    a_set: assert property (p_set)
        else $error("set time not loaded");

    // Counter holds and prescaler steps between ticks
    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (!tick && !set_time_stb) |=>
            ($stable(ts_reg) && pre_reg == $past(pre_reg) + PRE_W'(1));
    endproperty
    a_hold: assert property (p_hold)
        else $error("timestamp moved off tick");

    // Get answers with current value
    property p_get;
        @(posedge core_clk) disable iff (!rst_n)
        get_any |=> (time_valid && time_value == $past(ts_reg));
    endproperty
    a_get: assert property (p_get)
        else $error("get time wrong");

    // SMI follows pre-timeout in SMI mode
    property p_smi;
        @(posedge core_clk) disable iff (!rst_n)
        (pretimeout_stb && pretimeout_smi_en) |=> smi_out;
    endproperty
    a_smi: assert property (p_smi)
        else $error("smi not asserted");

    // Full count holds until a clear runs
    property p_cap;
        @(posedge core_clk) disable iff (!rst_n)
        (log_full && !log_clear_busy) |=> $stable(log_count);
    endproperty
    a_cap: assert property (p_cap)
        else $error("log over capacity");
endmodule

/* rtl/etnc_pkg.sv */
// Purpose: Shared constants for the event timestamp and NMI control block
// Assumes: core clock of 40 MHz
// Notes:   All counts derive from times given in their own units
package etnc_pkg;

    // Core clock rate in Hz
    localparam int unsigned CLK_HZ        = 40000000;
    // Tick period of the timestamp in ms
    localparam int unsigned TICK_MS       = 1000;
    // Cycles per one-second tick
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    // Diagnostic interrupt pulse width in ms
    localparam int unsigned NMI_MS        = 200;
    // Cycles of one pulse, rounded down
    localparam int unsigned NMI_CYCLES    = CLK_HZ / 1000 * NMI_MS;
    // Log clear completion allowance in ms
    localparam int unsigned LOG_CLEAR_MS  = 60000;

    // Timestamp width and reset value
    localparam int unsigned TS_W          = 32;
    localparam logic [31:0] TS_RESET      = 32'h0000_0000;
    // Upper bound of relative time window, as printed (33 bits)
    localparam logic [32:0] TS_REL_LIMIT  = 33'h1_4000_0000;

    // Event log geometry
    localparam int unsigned LOG_DEPTH     = 92;
    localparam int unsigned LOG_AW        = 7;
    // Entry: timestamp, sensor type, offset
    localparam int unsigned LOG_DW        = 48;

    // Button event codes
    localparam logic [7:0]  SENS_CRIT_INT = 8'h13;
    localparam logic [7:0]  OFS_DIAG_BTN  = 8'h6f;

    // Prescaler and pulse width counter widths
    localparam int unsigned PRE_W         = 26;
    localparam int unsigned NMI_W         = 24;

    // Clear state machine
    typedef enum logic [1:0] {
        ETNC_CLR_IDLE = 2'b01,
        ETNC_CLR_RUN  = 2'b10
    } etnc_clr_t;

endpackage

/* rtl/etnc_log_mem.sv */
// Purpose: Event log storage, one write and one registered read port
// Assumes: depth and width from the package
// Notes:   Read data is registered, one cycle latency
`timescale 1ns/100ps
module etnc_log_mem
    import etnc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              wr_en,
    input  wire logic [LOG_AW-1:0] wr_addr,
    input  wire logic [LOG_DW-1:0] wr_data,
    input  wire logic [LOG_AW-1:0] rd_addr,
    output logic      [LOG_DW-1:0] rd_data
);

    // Storage array, no reset so it maps to RAM
    logic [LOG_DW-1:0] mem [LOG_DEPTH];

    // Write port and registered read
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

/* testbench/etnc_host_model.sv */
// Purpose: Host chipset side that receives the NMI and SMI lines
// Assumes: smi_out is a level held until acknowledged
// Notes:   Answers promptly or slowly as slow_ack selects
`timescale 1ns/100ps
module etnc_host_model (
    input  wire logic core_clk,
    input  wire logic nmi_out,
    input  wire logic smi_out,
    input  wire logic slow_ack,
    output logic      smi_ack,
    output int        nmi_edges,
    output int        smi_seen
);
    logic nmi_prev  = 1'b0; // Last sampled NMI level
    int   nmi_count = 0;    // Pulse starts so far, one driver
    assign nmi_edges = nmi_count;

    // Count pulse starts, so a second pulse would show
    always @(posedge core_clk) begin
        if (nmi_out === 1'b1 && nmi_prev !== 1'b1) begin
            nmi_count <= nmi_count + 1;
        end
        nmi_prev <= nmi_out;
    end

    // Service an SMI, then acknowledge it for one cycle
    initial begin
        smi_ack   = 1'b0;
        smi_seen  = 0;
        forever begin
            @(posedge core_clk);
            if (smi_out === 1'b1) begin
                repeat (slow_ack ? 40 : 1) @(posedge core_clk);
                #1 smi_ack = 1'b1;
                @(posedge core_clk);
                #1 smi_ack = 1'b0;
                smi_seen = smi_seen + 1;
            end
        end
    end
endmodule

/* testbench/event_timestamp_and_nmi_control_bench.sv */
// Purpose: Self-checking bench for the timestamp, log and NMI block
// Assumes: tick and pulse lengths exceed the whole run
// Notes:   Lockout is judged by the host's count of pulse starts
`timescale 1ns/100ps
module event_timestamp_and_nmi_control_bench
    import etnc_pkg::*;
;
    logic              core_clk = 1'b0, rst_n = 1'b0, sys_reset = 1'b0;
    logic              set_time_stb = 1'b0, chassis_diag_stb = 1'b0;
    logic              get_log_time_stb = 1'b0, get_repo_time_stb = 1'b0;
    logic              diag_button_pin = 1'b0, filter_nmi_match = 1'b0;
    logic              pretimeout_stb = 1'b0, pretimeout_nmi_en = 1'b0;
    logic              pretimeout_smi_en = 1'b0, evt_msg_stb = 1'b0;
    logic              log_rd_stb = 1'b0, log_clear_stb = 1'b0;
    logic              slow_ack = 1'b0, smi_ack;
    logic [TS_W-1:0]   set_time_val = 32'h0000_0000, time_value, mdl_ts;
    logic [7:0]        evt_msg_type = 8'h00, evt_msg_ofs = 8'h00;
    logic [7:0]        filt_type, filt_ofs;
    logic [LOG_AW-1:0] log_rd_addr = 7'h00, log_count;
    logic [LOG_DW-1:0] log_rd_data;
    logic [LOG_DW-1:0] mdl_log[$];  // Expected log entries
    logic              time_valid, time_is_relative, nmi_out, smi_out;
    logic              evt_to_filter, log_rd_valid, log_full;
    logic              log_clear_busy;
    int                miscompares = 0, tests_run = 0, mdl_nmi = 0;
    int                mdl_smi = 0, nmi_edges, smi_seen;
    int                seed = 32'h416edc9a;

    etnc_top u_etnc_top (.core_clk, .rst_n, .sys_reset, .set_time_stb,
        .set_time_val, .get_log_time_stb, .get_repo_time_stb, .time_valid,
        .time_value, .time_is_relative, .chassis_diag_stb, .diag_button_pin,
        .filter_nmi_match, .pretimeout_stb, .pretimeout_nmi_en,
        .pretimeout_smi_en, .nmi_out, .smi_out, .smi_ack, .evt_msg_stb,
        .evt_msg_type, .evt_msg_ofs, .evt_to_filter, .filt_type, .filt_ofs,
        .log_rd_stb, .log_rd_addr, .log_rd_data, .log_rd_valid, .log_count,
        .log_full, .log_clear_stb, .log_clear_busy);
    etnc_host_model u_etnc_host_model (.core_clk, .nmi_out, .smi_out,
        .slow_ack, .smi_ack, .nmi_edges, .smi_seen);

    // 40 MHz core clock
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [LOG_DW-1:0] seen,
                         input logic [LOG_DW-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Inputs always move 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        step(20);
        rst_n = 1'b1;
        mdl_ts = TS_RESET;
        mdl_log.delete();
    endtask

    // Load a random time, as firmware does during self test
    task automatic set_time();
        mdl_ts = $random(seed);
        set_time_val = mdl_ts;
        set_time_stb = 1'b1;
        step(1);
        set_time_stb = 1'b0;
    endtask

    // Only the chosen strobe moves, so two reads may run back to back
    task automatic get_time(input bit repo);
        if (repo) get_repo_time_stb = 1'b1;
        else get_log_time_stb = 1'b1;
        step(1);
        if (repo) get_repo_time_stb = 1'b0;
        else get_log_time_stb = 1'b0;
        check("time_valid", time_valid, 1);
        check("time_value", time_value, mdl_ts);
        check("time_is_relative", time_is_relative, 1);
    endtask

    // Caller holds evt_msg_stb; one message per cycle
    task automatic send_evt();
        evt_msg_type = 8'($random(seed));
        evt_msg_ofs = 8'($random(seed));
        step(1);
        check("evt_to_filter", evt_to_filter, 1);
        check("filt", {filt_type, filt_ofs}, {evt_msg_type, evt_msg_ofs});
        if (mdl_log.size() < LOG_DEPTH) begin
            mdl_log.push_back({mdl_ts, evt_msg_type, evt_msg_ofs});
        end
    endtask

    // Count, full flag, then every entry read back to back
    task automatic check_log();
        check("log_count", log_count, LOG_DW'(mdl_log.size()));
        check("log_full", log_full, mdl_log.size() == LOG_DEPTH);
        // Strobe raised per entry, so an empty log leaves it quiet
        foreach (mdl_log[i]) begin
            log_rd_stb = 1'b1;
            log_rd_addr = LOG_AW'(i);
            step(1);
            check("log_rd_data", log_rd_data, mdl_log[i]);
            check("log_rd_valid", log_rd_valid, 1);
        end
        log_rd_stb = 1'b0;
    endtask

    task automatic set_trig(input int src);
        chassis_diag_stb = src == 0 || src == 4;
        diag_button_pin = src == 1 || src == 4;
        filter_nmi_match = src == 2 || src == 4;
        pretimeout_stb = src == 3 || src == 4;
    endtask

    // Source 0..3 alone, 4 all in one cycle
    task automatic nmi_case(input int src);
        do_reset();
        set_time();
        pretimeout_nmi_en = 1'b1;
        set_trig(src);
        step(1);
        {chassis_diag_stb, filter_nmi_match, pretimeout_stb} = 3'b000;
        // Button passes a synchroniser, so allow a few cycles
        for (int i = 0; i < 8 && nmi_out !== 1'b1; i++) step(1);
        mdl_nmi++;
        check("nmi_out", nmi_out, 1);
        // Hold the button past the synchroniser, even when locked
        step(4);
        if (diag_button_pin) begin
            mdl_log.push_back({mdl_ts, SENS_CRIT_INT, OFS_DIAG_BTN});
        end
        diag_button_pin = 1'b0;
        step(4);
        check_log();
        // Triggers while locked, then with a system reset, mid-pulse
        {chassis_diag_stb, filter_nmi_match, pretimeout_stb} = 3'b111;
        step(2);
        set_trig(4);
        sys_reset = 1'b1;
        step(6);
        set_trig(5);
        sys_reset = 1'b0;
        step(1000);
        check("nmi_out", nmi_out, 1);
        check("nmi_edges", nmi_edges, mdl_nmi);
        pretimeout_nmi_en = 1'b0;
    endtask

    task automatic smi_case(input bit slow);
        slow_ack = slow;
        pretimeout_smi_en = 1'b1;
        pretimeout_stb = 1'b1;
        step(1);
        pretimeout_stb = 1'b0;
        check("smi_out", smi_out, 1);
        step(60);
        check("smi_out", smi_out, 0);
        check("smi_seen", smi_seen, ++mdl_smi);
        check("nmi_out", nmi_out, 0);
        pretimeout_smi_en = 1'b0;
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        do_reset();
        check("time_value", time_value, TS_RESET);
        check("idle", {nmi_out, smi_out, log_count, log_full}, 0);
        get_time(0);
        get_time(1);
        set_time();
        get_time(0);
        get_time(1);
        step(1000);
        get_time(0);
        evt_msg_stb = 1'b1;
        repeat (LOG_DEPTH + 1) send_evt();
        evt_msg_stb = 1'b0;
        step(1);
        check_log();
        log_clear_stb = 1'b1;
        step(1);
        log_clear_stb = 1'b0;
        check("log_clear_busy", log_clear_busy, 1);
        step(1);
        mdl_log.delete();
        check("log_clear_busy", log_clear_busy, 0);
        check_log();
        for (int s = 0; s < 5; s++) nmi_case(s);
        do_reset();
        smi_case(1'b0);
        smi_case(1'b1);
        give_verdict();
    end

    // Hang guard, far beyond the expected run
    initial begin
        #(25 * 40000);
        miscompares++;
        give_verdict();
    end
endmodule
